// ---- hw/xdata_cfg.svh ----
`ifndef XDATA_CFG_SVH
`define XDATA_CFG_SVH
// register indexes, byte address is index times four
`define XD_IDX_DPL0    8'h82
`define XD_IDX_DPH0    8'h83
`define XD_IDX_DPL1    8'h84
`define XD_IDX_DPH1    8'h85
`define XD_IDX_DPS     8'h86
`define XD_IDX_CLOCK_CONTROL_REG   8'h8E
`define XD_IDX_PORT2   8'hA0
`define XD_IDX_INDEX   8'hC0
`define XD_IDX_WDATA   8'hC1
`define XD_IDX_CMD     8'hC2
`define XD_IDX_RDATA   8'hC3
// field positions
`define XD_CMD_WRITE   0
`define XD_CMD_PTR     1
`define XD_STR_MSB     2
// reset values
`define XD_RST_STRETCH 3'h1
`define XD_RST_PORT2   8'hFF
// timing, one machine cycle is four states
`define XD_STATES      3'h4
`define XD_LAST_STATE  2'h3
`endif

// ---- hw/xdata_pkg.sv ----
package xdata_pkg;
   // move sequencer states, gray along the path
   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_ALIGN  = 2'b01,
      ST_FETCH  = 2'b11,
      ST_ACCESS = 2'b10
   } state_t;
   // external bus pins
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0]  dout;
      logic        oe_n;
      logic        rd_n;
      logic        wr_n;
   } xbus_t;
   // latched move command
   typedef struct packed {
      logic       ptr;
      logic       write;
      logic [2:0] stretch;
   } cmd_t;
endpackage

// ---- hw/xdata_stretch.sv ----
// Our own choice: the APB register port.
`timescale 1ns/1ps
`include "xdata_cfg.svh"
// Summary of operation
// (R1) moves reach off-chip memory and peripherals
// (R2) same result, only strobe timing differs
// (R3) indirect form: index low, port2 high
// (R4) pointer form drives full selected pointer
// (R5) two pointers, select bit at 86h
// (R6) select 0 first pointer, 1 second
// (R7) upper select bits ignored, read zero
// (R8) four-clock fetch, then address and access
// (R9) stretch 0-7 gives 2-9 machine cycles
// (R10) stretch lengthens only external moves
// (R11) stretch resets to one, three cycles
// (R12) stretch zero: two cycles, 2-clock strobe
// (R13) stretch n: strobe 4n clocks wide
// (R14) four fixed states per machine cycle
// (R15) far side finishes within strobe width
module xdata_stretch
   import xdata_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // external data bus
   output logic      [15:0] xaddr,
   output logic      [7:0]  xdata_out,
   output logic             xdata_oe_n,
   input  wire logic [7:0]  xdata_in,
   output logic             rd_n,
   output logic             wr_n,
   // core status
   output logic             cpu_hold
);
   state_t      state_reg, state_next;
   xbus_t       bus_reg, bus_next;
   cmd_t        cmd_reg;
   logic [1:0]  phase_reg;
   logic [5:0]  cnt_reg;
   logic [5:0]  cnt_next;
   logic [15:0] dptr0_reg, data_pointer_second_reg, addr_lat;
   logic [7:0]  port2_reg, index_reg, wdata_reg, rdata_reg;
   logic        sel_reg;
   logic [2:0]  stretch_reg;
   logic [7:0]  s1_reg, s2_reg, s3_reg, din_reg;
   logic [31:0] prdata_reg, rd_mux;
   logic        pready_reg, pslverr_reg, hold_reg;
   logic        rd_end_reg;

   // apb decode
   wire [7:0] idx     = paddr[9:2];
   wire       aligned = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0);
   wire       h_dpl0  = aligned && idx == `XD_IDX_DPL0;
   wire       h_dph0  = aligned && idx == `XD_IDX_DPH0;
   wire       h_dpl1  = aligned && idx == `XD_IDX_DPL1;
   wire       h_dph1  = aligned && idx == `XD_IDX_DPH1;
   wire       h_dps   = aligned && idx == `XD_IDX_DPS;
   wire       h_clock_control_reg = aligned && idx == `XD_IDX_CLOCK_CONTROL_REG;
   wire       h_port2 = aligned && idx == `XD_IDX_PORT2;
   wire       h_index = aligned && idx == `XD_IDX_INDEX;
   wire       h_wdata = aligned && idx == `XD_IDX_WDATA;
   wire       h_cmd   = aligned && idx == `XD_IDX_CMD;
   wire       h_rdata = aligned && idx == `XD_IDX_RDATA;
   wire       mapped  = h_dpl0 | h_dph0 | h_dpl1 | h_dph1 | h_dps | h_clock_control_reg
                      | h_port2 | h_index | h_wdata | h_cmd | h_rdata;
   wire       acc     = psel && penable && pready_reg;
   wire       wr      = acc && pwrite && mapped;
   wire       idle    = state_reg == ST_IDLE;
   wire       cmd_go  = wr && h_cmd && idle;

   // read mux, narrow registers in the low bits
   assign rd_mux = h_dpl0  ? {24'h0, dptr0_reg[7:0]}
                 : h_dph0  ? {24'h0, dptr0_reg[15:8]}
                 : h_dpl1  ? {24'h0, data_pointer_second_reg[7:0]}
                 : h_dph1  ? {24'h0, data_pointer_second_reg[15:8]}
                 : h_dps   ? {31'h0, sel_reg}            // [R7]
                 : h_clock_control_reg ? {29'h0, stretch_reg}
                 : h_port2 ? {24'h0, port2_reg}
                 : h_index ? {24'h0, index_reg}
                 : h_wdata ? {24'h0, wdata_reg}
                 : h_cmd   ? {31'h0, ~idle}
                 : h_rdata ? {24'h0, rdata_reg}
                 : 32'h0;

   // apb answer, one access cycle, error on unmapped
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= 32'h0;
      end else begin
         pready_reg  <= psel && !penable;
         pslverr_reg <= psel && !penable && !mapped;
         prdata_reg  <= (psel && !penable && !pwrite) ? rd_mux : 32'h0;
      end
   end

   // software registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dptr0_reg   <= 16'h0;
         data_pointer_second_reg   <= 16'h0;
         sel_reg     <= 1'b0;
         stretch_reg <= `XD_RST_STRETCH;                 // [R11]
         port2_reg   <= `XD_RST_PORT2;
         index_reg   <= 8'h0;
         wdata_reg   <= 8'h0;
      end else if (wr) begin
         if (h_dpl0) dptr0_reg[7:0] <= pwdata[7:0];
         if (h_dph0) dptr0_reg[15:8] <= pwdata[7:0];
         if (h_dpl1) data_pointer_second_reg[7:0] <= pwdata[7:0];
         if (h_dph1) data_pointer_second_reg[15:8] <= pwdata[7:0];
         if (h_dps) sel_reg <= pwdata[0];               // [R5] [R7]
         if (h_clock_control_reg) stretch_reg <= pwdata[`XD_STR_MSB:0]; // [R9]
         if (h_port2) port2_reg <= pwdata[7:0];
         if (h_index) index_reg <= pwdata[7:0];
         if (h_wdata) wdata_reg <= pwdata[7:0];
      end
   end

   // address of the move, chosen when it is issued
   wire [15:0] ptr_sel  = sel_reg ? data_pointer_second_reg : dptr0_reg;      // [R6]
   wire        ptr_form = pwdata[`XD_CMD_PTR];
   wire [15:0] addr_new = ptr_form ? ptr_sel                    // [R4]
                        : {port2_reg, index_reg};              // [R3]

   // command latch; stretch frozen for the whole move
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cmd_reg  <= '0;
         addr_lat <= 16'h0;
      end else if (cmd_go) begin
         cmd_reg  <= {ptr_form, pwdata[`XD_CMD_WRITE], stretch_reg};
         addr_lat <= addr_new;
      end
   end

   // free running state counter c1..c4
   always_ff @(posedge clk or posedge rst) begin
      if (rst) phase_reg <= 2'h0;
      else phase_reg <= phase_reg + 2'h1;               // [R14]
   end

   // sequencer terms
   wire [5:0] last_cnt  = {1'b0, cmd_reg.stretch, 2'b11};
   wire       fetch_end = state_reg == ST_FETCH && phase_reg == `XD_LAST_STATE;
   wire       acc_end   = state_reg == ST_ACCESS && cnt_reg == last_cnt;
   wire       in_acc_nx = fetch_end || (state_reg == ST_ACCESS && !acc_end);
   assign cnt_next = fetch_end ? 6'h0
                   : (state_reg == ST_ACCESS) ? cnt_reg + 6'h1 : cnt_reg;
   wire       win0  = cnt_next == 6'h1 || cnt_next == 6'h2;      // [R12]
   wire       winn  = cnt_next[5:2] != 4'h0;                     // [R13]
   wire       strb_nx = in_acc_nx && ((cmd_reg.stretch == 3'h0) ? win0 : winn);

   // move sequencer
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE:   if (cmd_go) state_next = ST_ALIGN;
         ST_ALIGN:  if (phase_reg == `XD_LAST_STATE) state_next = ST_FETCH;
         ST_FETCH:  if (fetch_end) state_next = ST_ACCESS;   // [R8]
         ST_ACCESS: if (acc_end) state_next = ST_IDLE;       // [R9] [R10]
         default:   state_next = ST_IDLE;
      endcase
   end

   // external pins from the next sequencer view
   always_comb begin
      bus_next      = bus_reg;
      bus_next.addr = in_acc_nx ? addr_lat : 16'h0;          // [R8]
      bus_next.dout = (in_acc_nx && cmd_reg.write) ? wdata_reg : 8'h0;
      bus_next.oe_n = !(in_acc_nx && cmd_reg.write);
      bus_next.rd_n = !(strb_nx && !cmd_reg.write);         // [R1]
      bus_next.wr_n = !(strb_nx && cmd_reg.write);          // [R1]
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg <= ST_IDLE;
         cnt_reg   <= 6'h0;
         bus_reg   <= '{16'h0, 8'h0, 1'b1, 1'b1, 1'b1};
         hold_reg  <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         bus_reg   <= bus_next;
         hold_reg  <= state_next != ST_IDLE;                // [R10]
      end
   end

   // read data pin, three flops, taken once two agree
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s1_reg  <= 8'h0;
         s2_reg  <= 8'h0;
         s3_reg  <= 8'h0;
         din_reg <= 8'h0;
      end else begin
         s1_reg <= xdata_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         if (s2_reg == s3_reg) din_reg <= s3_reg;
      end
   end

   // read result taken one clock after the move ends; the pin needs the
   // synchroniser's latency, which a stretch-zero strobe alone cannot cover
   wire rd_last = !bus_reg.rd_n && bus_next.rd_n;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rd_end_reg <= 1'b0;
         rdata_reg  <= 8'h0;
      end else begin
         rd_end_reg <= acc_end && !cmd_reg.write;
         if (rd_end_reg) rdata_reg <= din_reg;             // [R2]
      end
   end

   // outputs
   assign prdata     = prdata_reg;
   assign pready     = pready_reg;
   assign pslverr    = pslverr_reg;
   assign xaddr      = bus_reg.addr;
   assign xdata_out  = bus_reg.dout;
   assign xdata_oe_n = bus_reg.oe_n;
   assign rd_n       = bus_reg.rd_n;
   assign wr_n       = bus_reg.wr_n;
   assign cpu_hold   = hold_reg;

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   wire       strb = !bus_reg.rd_n || !bus_reg.wr_n;
   logic [5:0] width_reg;
   logic [6:0] tot_reg;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         width_reg <= 6'h0;
         tot_reg   <= 7'h0;
      end else begin
         width_reg <= strb ? width_reg + 6'h1 : 6'h0;
         tot_reg   <= (state_reg == ST_ALIGN) ? 7'h0 : tot_reg + 7'h1;
      end
   end
   wire [5:0] exp_w = (cmd_reg.stretch == 3'h0) ? 6'h2 : {1'b0, cmd_reg.stretch, 2'b00};

   strobe_width_a: assert property ($fell(strb) |-> width_reg == exp_w) // [R13]
      else $error("strobe width wrong");
   fast_width_a: assert property ($fell(strb) && cmd_reg.stretch == 3'h0 |-> width_reg == 6'h2) // [R12]
      else $error("stretch zero strobe not two clocks");
   move_length_a: assert property (acc_end |-> tot_reg + 7'h1 == {2'b0, cmd_reg.stretch, 2'b00} + 7'h8) // [R9]
      else $error("move length wrong");
   fetch_len_a: assert property ($rose(state_reg == ST_FETCH) |-> (state_reg == ST_FETCH)[*4] ##1 state_reg == ST_ACCESS) // [R8]
      else $error("fetch not four clocks");
   phase_order_a: assert property (!$past(rst) |-> phase_reg == $past(phase_reg) + 2'h1) // [R14]
      else $error("state order broken");
   ptr_addr_a: assert property ($rose(state_reg == ST_ALIGN) && cmd_reg.ptr |-> addr_lat == $past(ptr_sel)) // [R4]
      else $error("pointer address wrong");
   idx_addr_a: assert property ($rose(state_reg == ST_ALIGN) && !cmd_reg.ptr |-> addr_lat == $past({port2_reg, index_reg})) // [R3]
      else $error("indirect address wrong");
   sel_write_a: assert property (wr && h_dps |=> sel_reg == $past(pwdata[0])) // [R5]
      else $error("select bit not stored");
   dps_upper_a: assert property (acc && !pwrite && h_dps |-> prdata_reg[31:1] == 31'h0) // [R7]
      else $error("select upper bits not zero");
   strobe_idle_a: assert property (idle |-> bus_reg.rd_n && bus_reg.wr_n) // [R10]
      else $error("strobe outside a move");
   wr_drive_a: assert property (!bus_reg.wr_n |-> !bus_reg.oe_n && bus_reg.dout == wdata_reg) // [R1]
      else $error("write data not driven");
   reset_str_a: assert property ($fell(rst) |-> stretch_reg == `XD_RST_STRETCH) // [R11]
      else $error("stretch reset value wrong");

   // bus pins around a move
   oe_idle_a: assert property (idle |-> bus_reg.oe_n && bus_reg.addr == 16'h0) // [R8]
      else $error("bus driven outside a move");
   addr_access_a: assert property (state_reg == ST_ACCESS |-> bus_reg.addr == addr_lat) // [R8]
      else $error("address missing during access");
   fetch_strobe_a: assert property (state_reg == ST_FETCH |-> bus_reg.rd_n && bus_reg.wr_n) // [R8]
      else $error("strobe during fetch");
   read_no_drive_a: assert property (!bus_reg.rd_n |-> bus_reg.oe_n) // [R1]
      else $error("data driven during read");

   // move bookkeeping and apb answer
   hold_start_a: assert property (cmd_go |=> hold_reg) // [R10]
      else $error("hold not raised for a move");
   move_freeze_a: assert property (!idle |=> $stable(cmd_reg) && $stable(addr_lat)) // [R9]
      else $error("move settings changed mid move");
   err_answer_a: assert property (pslverr_reg |-> pready_reg) // [R1]
      else $error("error without ready");

   read_move_c: cover property (rd_last);
   write_move_c: cover property ($fell(strb) && cmd_reg.write);
   long_move_c: cover property (acc_end && cmd_reg.stretch == 3'h7);
   fast_move_c: cover property (acc_end && cmd_reg.stretch == 3'h0);
   second_ptr_c: cover property (cmd_go && ptr_form && sel_reg);
endmodule

// ---- dv/xdata_mem_model.sv ----
`timescale 1ns/1ps
module xdata_mem_model (
   // clock
   input  wire logic        clk,
   // bus from the block
   input  wire logic [15:0] xaddr,
   input  wire logic [7:0]  xdata_out,
   input  wire logic        xdata_oe_n,
   input  wire logic        wr_n,
   // read data to the block
   output logic      [7:0]  xdata_in
);
   logic [7:0] mem [0:65535];
   logic [7:0] last_reg;
   // write captured on every strobe clock, last one stands
   always_ff @(posedge clk) begin
      if (wr_n === 1'b0) mem[xaddr] <= xdata_out;
      last_reg <= xdata_in;
   end
   // answers from the address on; while the block drives, shows a changing pattern
   assign xdata_in = xdata_oe_n ? mem[xaddr] : ~last_reg;
endmodule

// ---- dv/xdata_stretch_tb_top.sv ----
`timescale 1ns/1ps
`include "xdata_cfg.svh"
module xdata_stretch_tb_top;
   import xdata_pkg::*;
   logic        clk, rst, psel, penable, pwrite, pready, pslverr, oe_n, rd_n, wr_n, hold, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] xaddr;
   logic [7:0]  dout, din;
   int          num_errors = 0;
   int          cmp_count = 0;

   xdata_stretch u_xdata_stretch (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .xaddr(xaddr),
      .xdata_out(dout), .xdata_oe_n(oe_n), .xdata_in(din), .rd_n(rd_n), .wr_n(wr_n), .cpu_hold(hold));
   xdata_mem_model u_xdata_mem_model (.clk(clk), .xaddr(xaddr), .xdata_out(dout), .xdata_oe_n(oe_n),
      .wr_n(wr_n), .xdata_in(din));

   // clock and watchdog
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      results();
   end

   task results();
      $display("errors %0d comparisons %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask

   // one apb transfer, waits for pready
   task apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {2'h0, idx, 2'h0};
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      chk("pready", 32'h1, {31'h0, pready});
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task wr(input logic [7:0] idx, input logic [31:0] d);
      apb(1'b1, idx, d);
   endtask

   task rdc(input logic [7:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 32'h0);
      chk("prdata", exp, rd);
   endtask

   // issue a move and time it at the pins
   task mv(input logic [7:0] cmd, input int n, input logic [15:0] a);
      int h, s;
      h = 0;
      s = 0;
      wr(`XD_IDX_CMD, {24'h0, cmd});
      for (int i = 0; i < 60 && !(h > 0 && hold === 1'b0); i++) begin
         @(posedge clk);
         if (hold === 1'b1) h++;
         if (rd_n === 1'b0 || wr_n === 1'b0) begin
            s++;
            chk("xaddr", {16'h0, a}, {16'h0, xaddr});
            chk("write strobe", {31'h0, cmd[`XD_CMD_WRITE]}, {31'h0, ~wr_n});
         end
      end
      chk("strobe width", (n == 0) ? 2 : 4 * n, s);
      chk("move length", 1, {31'h0, h >= 4 * n + 9 && h <= 4 * n + 12});
      rdc(`XD_IDX_CMD, 32'h0);
   endtask

   task t_regs();
      rdc(`XD_IDX_DPS, 32'h0);
      rdc(`XD_IDX_CLOCK_CONTROL_REG, 32'h1);
      rdc(`XD_IDX_PORT2, 32'hFF);
      apb(1'b0, 8'h10, 32'h0);
      chk("pslverr", 32'h1, {31'h0, err});
      wr(`XD_IDX_DPS, 32'hFF);
      rdc(`XD_IDX_DPS, 32'h1);
   endtask

   // every stretch value, second pointer, write moves
   task t_ptr();
      wr(`XD_IDX_DPL1, 32'h34);
      wr(`XD_IDX_DPH1, 32'h12);
      for (int n = 0; n < 8; n++) begin
         wr(`XD_IDX_CLOCK_CONTROL_REG, n);
         wr(`XD_IDX_WDATA, 32'h50 + n);
         mv(8'h03, n, 16'h1234);
      end
   endtask

   // second reset, then indirect and first-pointer reads
   task t_ind();
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      wr(`XD_IDX_PORT2, 32'h12);
      wr(`XD_IDX_INDEX, 32'h34);
      mv(8'h00, 1, 16'h1234);
      rdc(`XD_IDX_RDATA, 32'h57);
      wr(`XD_IDX_DPL0, 32'h34);
      wr(`XD_IDX_DPH0, 32'h12);
      wr(`XD_IDX_CLOCK_CONTROL_REG, 32'h0);
      wr(`XD_IDX_WDATA, 32'hA5);
      mv(8'h03, 0, 16'h1234);
      mv(8'h02, 0, 16'h1234);
      rdc(`XD_IDX_RDATA, 32'hA5);
   endtask

   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h0;
      pwdata = 32'h0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_ptr();
      t_ind();
      results();
   end
endmodule
